// file: rtl/bsx_core.sv
`timescale 1ns/1ps
module bsx_core (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  logic [15:0]         gpr_q [bsx_pkg::GPR_COUNT];
  logic [15:0]         gpr_d [bsx_pkg::GPR_COUNT];
  bsx_pkg::bsx_ccr_t   ccr_q;
  bsx_pkg::bsx_ccr_t   ccr_d;
  bsx_pkg::bsx_state_t state_q;
  bsx_pkg::bsx_state_t state_d;
  bsx_pkg::bsx_instr_t instr_q;
  bsx_pkg::bsx_instr_t instr_d;
  bsx_pkg::bsx_op_t    last_op_q;
  bsx_pkg::bsx_op_t    last_op_d;
  logic                illegal_q;
  logic                illegal_d;
  logic [31:0]         prdata_q;
  logic [31:0]         prdata_d;
  logic                pready_q;
  logic                pready_d;
  logic                pslverr_q;
  logic                pslverr_d;
  logic                acc_done;
  logic                acc_first;
  logic [31:0]         wr_word;
  logic [15:0]         source_register_val;
  logic [15:0]         rd_val;
  logic [4:0]          dig_lo;
  logic [4:0]          dig_hi;
  logic [15:0]         ext_word;

  // One BCD digit minus digit minus borrow; bit 4 is borrow out
  function automatic logic [4:0] bcd_digit_sub(input logic [3:0] a, input logic [3:0] b, input logic bin);
    logic [4:0] t;
    t = {1'b0, a} - {1'b0, b} - {4'h0, bin};
    if (t[4]) begin
      bcd_digit_sub = {1'b1, 4'(t[3:0] - bsx_pkg::BCD_ADJ)};
    end else begin
      bcd_digit_sub = {1'b0, t[3:0]};
    end
  endfunction

  // Merge write data into old word under byte strobes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = wd[8*i +: 8];
      end
    end
    lane_merge = m;
  endfunction

  function automatic logic addr_is_gpr(input logic [7:0] a);
    addr_is_gpr = (a[7:5] == bsx_pkg::OFS_GPR_BASE[7:5]) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = addr_is_gpr(a) || (a == bsx_pkg::OFS_INSTR) || (a == bsx_pkg::OFS_CCR)
                  || (a == bsx_pkg::OFS_STATUS);
  endfunction

  // Three-byte opcode image: first byte in [23:16], last in [7:0]
  function automatic bsx_pkg::bsx_instr_t decode(input logic [23:0] w);
    bsx_pkg::bsx_instr_t r;
    r.op  = bsx_pkg::BSX_OP_NONE;
    r.src = w[18:16];
    r.dst = w[18:16];
    if (w[23:19] == bsx_pkg::ENC_B1_PREFIX) begin
      if ((w[15:8] == bsx_pkg::ENC_B2_DECIMAL_SUBTRACT_BORROW)
          && (w[7:3] == bsx_pkg::ENC_B3_DECIMAL_SUBTRACT_BORROW)) begin
        r.op  = bsx_pkg::BSX_OP_DECIMAL_SUBTRACT_BORROW;
        r.dst = w[2:0];
      end else if (w[15:8] == bsx_pkg::ENC_B2_SIGN_EXTEND_BYTE) begin
        r.op = bsx_pkg::BSX_OP_SIGN_EXTEND_BYTE;
      end else if (w[15:8] == bsx_pkg::ENC_B2_ZERO_EXTEND_BYTE) begin
        r.op = bsx_pkg::BSX_OP_ZERO_EXTEND_BYTE;
      end
    end
    decode = r;
  endfunction

  function automatic logic [1:0] op_code(input bsx_pkg::bsx_op_t op);
    case (op)
      bsx_pkg::BSX_OP_DECIMAL_SUBTRACT_BORROW: op_code = bsx_pkg::STAT_OP_DECIMAL_SUBTRACT_BORROW;
      bsx_pkg::BSX_OP_SIGN_EXTEND_BYTE:        op_code = bsx_pkg::STAT_OP_SIGN_EXTEND_BYTE;
      bsx_pkg::BSX_OP_ZERO_EXTEND_BYTE:        op_code = bsx_pkg::STAT_OP_ZERO_EXTEND_BYTE;
      default:                                 op_code = bsx_pkg::STAT_OP_NONE;
    endcase
  endfunction

  assign acc_first = psel & penable & ~pready_q;
  assign acc_done  = psel & penable & pready_q;

  // APB answer: pready rises one cycle into the access phase
  always_comb begin
    pready_d  = acc_first;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (acc_first) begin
      pslverr_d = ~addr_mapped(paddr);
      if (!pwrite) begin
        if (addr_is_gpr(paddr)) begin
          prdata_d = {16'h0000, gpr_q[paddr[4:2]]};
        end else if (paddr == bsx_pkg::OFS_CCR) begin
          prdata_d = {28'h0000000, ccr_q};
        end else if (paddr == bsx_pkg::OFS_STATUS) begin
          prdata_d = 32'h0000_0000;
          prdata_d[bsx_pkg::STAT_BUSY_BIT]                   = (state_q == bsx_pkg::BSX_ST_EXEC);
          prdata_d[bsx_pkg::STAT_ILL_BIT]                    = illegal_q;
          prdata_d[bsx_pkg::STAT_OP_LSB +: 2]                = op_code(last_op_q);
        end
      end
    end
  end

  assign source_register_val = gpr_q[instr_q.src];
  assign rd_val   = gpr_q[instr_q.dst];
  assign dig_lo   = bcd_digit_sub(rd_val[3:0], source_register_val[3:0], ccr_q.c);
  assign dig_hi   = bcd_digit_sub(rd_val[7:4], source_register_val[7:4], dig_lo[4]);
  assign ext_word = (instr_q.op == bsx_pkg::BSX_OP_SIGN_EXTEND_BYTE) ? {{8{rd_val[7]}}, rd_val[7:0]}
                                                                     : {8'h00, rd_val[7:0]};

  // Datapath: register file, flags and sequencing
  always_comb begin
    wr_word   = 32'h0000_0000;
    state_d   = state_q;
    instr_d   = instr_q;
    last_op_d = last_op_q;
    illegal_d = illegal_q;
    ccr_d     = ccr_q;
    for (int i = 0; i < bsx_pkg::GPR_COUNT; i++) begin
      gpr_d[i] = gpr_q[i];
    end
    if (acc_done && pwrite) begin
      if (addr_is_gpr(paddr)) begin
        wr_word               = lane_merge({16'h0000, gpr_q[paddr[4:2]]}, pwdata, pstrb);
        gpr_d[paddr[4:2]]     = wr_word[15:0];
      end else if (paddr == bsx_pkg::OFS_CCR) begin
        wr_word = lane_merge({28'h0000000, ccr_q}, pwdata, pstrb);
        ccr_d   = wr_word[3:0];
      end else if (paddr == bsx_pkg::OFS_INSTR) begin
        wr_word   = lane_merge(32'h0000_0000, pwdata, pstrb);
        instr_d   = decode(wr_word[23:0]);
        illegal_d = (instr_d.op == bsx_pkg::BSX_OP_NONE);
        if (!illegal_d) begin
          state_d = bsx_pkg::BSX_ST_EXEC;
        end
      end
    end
    case (state_q)
      bsx_pkg::BSX_ST_IDLE: begin
      end
      bsx_pkg::BSX_ST_EXEC: begin
        state_d   = bsx_pkg::BSX_ST_IDLE;
        last_op_d = instr_q.op;
        case (instr_q.op)
          bsx_pkg::BSX_OP_DECIMAL_SUBTRACT_BORROW: begin
            gpr_d[instr_q.dst] = {rd_val[15:8], dig_hi[3:0], dig_lo[3:0]};
            ccr_d.z = ccr_q.z & ({dig_hi[3:0], dig_lo[3:0]} == 8'h00);
            ccr_d.c = dig_hi[4];
            ccr_d.n = ccr_q.n;
            ccr_d.v = ccr_q.v;
          end
          bsx_pkg::BSX_OP_SIGN_EXTEND_BYTE: begin
            gpr_d[instr_q.dst] = ext_word;
            ccr_d.n = ext_word[15];
            ccr_d.z = (ext_word == 16'h0000);
            ccr_d.v = 1'b0;
            ccr_d.c = 1'b0;
          end
          bsx_pkg::BSX_OP_ZERO_EXTEND_BYTE: begin
            gpr_d[instr_q.dst] = ext_word;
            ccr_d.z = (ext_word == 16'h0000);
            ccr_d.n = 1'b0;
            ccr_d.v = 1'b0;
            ccr_d.c = 1'b0;
          end
          default: begin
          end
        endcase
      end
      default: state_d = bsx_pkg::BSX_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < bsx_pkg::GPR_COUNT; i++) begin
        gpr_q[i] <= bsx_pkg::GPR_RST;
      end
      ccr_q     <= bsx_pkg::CCR_RST;
      state_q   <= bsx_pkg::BSX_ST_IDLE;
      instr_q   <= '0;
      last_op_q <= bsx_pkg::BSX_OP_NONE;
      illegal_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      for (int i = 0; i < bsx_pkg::GPR_COUNT; i++) begin
        gpr_q[i] <= gpr_d[i];
      end
      ccr_q     <= ccr_d;
      state_q   <= state_d;
      instr_q   <= instr_d;
      last_op_q <= last_op_d;
      illegal_q <= illegal_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule

// file: rtl/bsx_pkg.sv
// Operation
// - Packed BCD byte subtract with carry borrow
// - Decimal subtract keeps N and V
// - Z stays set only if result zero
// - C set on decimal borrow out, else cleared
// - Sign extend copies bit 7 upward
// - Sign extend sets N and Z from word
// - Sign extend clears V and C
// - Zero extend clears bits 8 to 15
// - Zero extend sets Z from word
// - Zero extend clears N, V and C
package bsx_pkg;

  localparam int unsigned GPR_COUNT     = 8;
  localparam int unsigned GPR_W         = 16;
  localparam int unsigned APB_AW        = 8;

  localparam logic [7:0]  OFS_INSTR     = 8'h00;
  localparam logic [7:0]  OFS_CCR       = 8'h04;
  localparam logic [7:0]  OFS_STATUS    = 8'h08;
  localparam logic [7:0]  OFS_GPR_BASE  = 8'h20;

  localparam logic [4:0]  ENC_B1_PREFIX = 5'h14;
  localparam logic [7:0]  ENC_B2_DECIMAL_SUBTRACT_BORROW = 8'h00;
  localparam logic [4:0]  ENC_B3_DECIMAL_SUBTRACT_BORROW = 5'h16;
  localparam logic [7:0]  ENC_B2_SIGN_EXTEND_BYTE        = 8'h11;
  localparam logic [7:0]  ENC_B2_ZERO_EXTEND_BYTE        = 8'h12;

  localparam logic [3:0]  BCD_ADJ       = 4'h6;

  localparam logic [1:0]  STAT_OP_NONE  = 2'h0;
  localparam logic [1:0]  STAT_OP_DECIMAL_SUBTRACT_BORROW = 2'h1;
  localparam logic [1:0]  STAT_OP_SIGN_EXTEND_BYTE        = 2'h2;
  localparam logic [1:0]  STAT_OP_ZERO_EXTEND_BYTE        = 2'h3;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_ILL_BIT  = 1;
  localparam int unsigned STAT_OP_LSB   = 2;

  localparam logic [15:0] GPR_RST       = 16'h0000;
  localparam logic [3:0]  CCR_RST       = 4'h0;

  typedef enum logic [1:0] {
    BSX_OP_NONE,
    BSX_OP_DECIMAL_SUBTRACT_BORROW,
    BSX_OP_SIGN_EXTEND_BYTE,
    BSX_OP_ZERO_EXTEND_BYTE
  } bsx_op_t;

  typedef enum logic {
    BSX_ST_IDLE,
    BSX_ST_EXEC
  } bsx_state_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } bsx_ccr_t;

  typedef struct packed {
    bsx_op_t    op;
    logic [2:0] src;
    logic [2:0] dst;
  } bsx_instr_t;

endpackage

// file: verification/bsx_core_sva.sv
`timescale 1ns/1ps
module bsx_core_sva (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic mapped;
  logic rd_resp;

  assign mapped = paddr inside {8'h00, 8'h04, 8'h08} || (paddr[7:5] == 3'b001 && paddr[1:0] == 2'b00);
  assign rd_resp = pready && !pwrite;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  rdy_pulse_a: assert property (pready && clk_en |=> !pready)
    else $error("pready stood longer than one cycle");
  rdy_latency_a: assert property (psel && clk_en && $rose(penable) |=> pready)
    else $error("pready late after access phase");
  rdy_cause_a: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready without a full access phase");
  err_cause_a: assert property (pslverr |-> pready && !mapped)
    else $error("pslverr on a mapped address");
  err_mapped_a: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access without pslverr");
  idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside a response");
  gpr_upper_a: assert property (rd_resp && paddr[7:5] == 3'b001 |-> prdata[31:16] == 16'h0000)
    else $error("register upper half not zero");
  status_done_a: assert property (rd_resp && paddr == 8'h08 |-> prdata[31:4] == 28'h0 && !prdata[0])
    else $error("instruction still busy at next transfer");
endmodule

bind bsx_core bsx_core_sva i_sva (.ref_clk, .arst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr);

// file: verification/bsx_cpu_model.sv
`timescale 1ns/1ps
module bsx_cpu_model (
  input  wire logic        ref_clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel    = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite  = 1'b0,
  output logic      [7:0]  paddr   = 8'h00,
  output logic      [31:0] pwdata  = 32'h0000_0000,
  output logic      [3:0]  pstrb   = 4'h0
);
  // One APB transfer; ok stays low if no answer comes within the bound
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge ref_clk);
      ok = pready;
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
    pstrb   <= 4'h0;
  endtask
endmodule

// file: verification/tb_bcd_sub_and_byte_extend.sv
`timescale 1ns/1ps
module tb_bcd_sub_and_byte_extend;
  typedef struct packed {
    logic [2:0]  source_register;
    logic [7:0]  op;
    logic [15:0] src;
    logic [15:0] dst;
    logic [3:0]  ccr;
    logic [15:0] ed;
    logic [3:0]  ec;
  } bsx_row_t;
  localparam logic [7:0] G2 = bsx_pkg::OFS_GPR_BASE + 8'h08;
  localparam logic [7:0] G3 = bsx_pkg::OFS_GPR_BASE + 8'h0C;
  bsx_row_t rows [10] = '{
    '{3'd2, 8'h00, 16'h0012, 16'hAB45, 4'hF, 16'hAB32, 4'hA},
    '{3'd2, 8'h00, 16'h0025, 16'h0010, 4'h0, 16'h0085, 4'h1},
    '{3'd2, 8'h00, 16'h0049, 16'h7750, 4'h5, 16'h7700, 4'h4},
    '{3'd2, 8'h00, 16'h0000, 16'h0000, 4'h8, 16'h0000, 4'h8},
    '{3'd2, 8'h00, 16'h0000, 16'h0000, 4'h3, 16'h0099, 4'h3},
    '{3'd3, 8'h00, 16'h0000, 16'h0042, 4'h1, 16'h0099, 4'h1},
    '{3'd3, 8'h11, 16'h0000, 16'h1280, 4'h7, 16'hFF80, 4'h8},
    '{3'd3, 8'h11, 16'h0000, 16'hFF00, 4'h3, 16'h0000, 4'h4},
    '{3'd3, 8'h12, 16'h0000, 16'hFF80, 4'hF, 16'h0080, 4'h0},
    '{3'd3, 8'h12, 16'h0000, 16'h5500, 4'hB, 16'h0000, 4'h4}};
  logic        ref_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        er;
  logic        ok;
  logic        clk_en = 1'b1;
  time         t0;
  int          miscompares = 0;
  int          comparisons = 0;

  bsx_core i_dut (.ref_clk, .arst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr);
  bsx_cpu_model i_cpu (.ref_clk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic give_verdict;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    i_cpu.xfer(w, a, d, s, rd, er, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: no bus answer", $time);
      give_verdict;
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
    acc(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rd, e);
    chk({31'h0, er}, {31'h0, ee});
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    rdc(bsx_pkg::OFS_CCR, 32'h0, 1'b0);
    rdc(G3, 32'h0, 1'b0);
    $display("Reset test done");
    for (int i = 0; i < 10; i++) begin
      acc(1'b1, G2, {16'h0, rows[i].src});
      acc(1'b1, G3, {16'h0, rows[i].dst});
      acc(1'b1, bsx_pkg::OFS_CCR, {28'h0, rows[i].ccr});
      acc(1'b1, bsx_pkg::OFS_INSTR, {8'h00, bsx_pkg::ENC_B1_PREFIX, rows[i].source_register, rows[i].op,
          bsx_pkg::ENC_B3_DECIMAL_SUBTRACT_BORROW, 3'd3});
      rdc(G3, {16'h0, rows[i].ed}, 1'b0);
      rdc(bsx_pkg::OFS_CCR, {28'h0, rows[i].ec}, 1'b0);
      $display("Row %0d done", i);
    end
    rdc(bsx_pkg::OFS_STATUS, {28'h0, bsx_pkg::STAT_OP_ZERO_EXTEND_BYTE, 2'b00}, 1'b0);
    rdc(bsx_pkg::OFS_INSTR, 32'h0, 1'b0);
    // Word-size subtract is refused: destination and flags must not move
    acc(1'b1, G2, 32'h0000_0011);
    acc(1'b1, G3, 32'h0000_0055);
    acc(1'b1, bsx_pkg::OFS_INSTR, {8'h00, 5'h15, 3'd2, 8'h00, bsx_pkg::ENC_B3_DECIMAL_SUBTRACT_BORROW, 3'd3});
    rdc(bsx_pkg::OFS_STATUS, {28'h0, bsx_pkg::STAT_OP_ZERO_EXTEND_BYTE, 2'b10}, 1'b0);
    rdc(G3, 32'h0000_0055, 1'b0);
    rdc(bsx_pkg::OFS_CCR, 32'h0000_0004, 1'b0);
    // Byte strobes merge only the selected lane
    acc(1'b1, G3, 32'hFFFF_FFFF);
    acc(1'b1, G3, 32'h0000_1234, 4'h1);
    rdc(G3, 32'h0000_FF34, 1'b0);
    acc(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk({31'h0, er}, 32'h0000_0001);
    rdc(8'h10, 32'h0, 1'b1);
    // Clock enable low stalls the answer; write lands once enabled
    clk_en <= 1'b0;
    t0 = $time;
    fork
      acc(1'b1, G3, 32'h0000_0077);
      begin
        repeat (5) @(posedge ref_clk);
        clk_en <= 1'b1;
      end
    join
    chk(32'(($time - t0) / 10), 32'd7);
    rdc(G3, 32'h0000_0077, 1'b0);
    $display("Awkward cases done");
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    rdc(G3, 32'h0, 1'b0);
    rdc(bsx_pkg::OFS_CCR, 32'h0, 1'b0);
    rdc(bsx_pkg::OFS_STATUS, 32'h0, 1'b0);
    $display("Mid-run reset test done");
    give_verdict;
  end
endmodule
